// ---- plc_cycle_supervisor.v ----
// Run control, output safety and process image sequencing
// Functional notes
// - Driven I/O channel reads back as one
// - Shorted channel reads back zero
// - Any output fault blinks fault indicator
// - Three byte input and output images
// - Pulse output only on last two
// - Relay variant: no indicators, no diagnostics
// - 100 ms watchdog forces STOP
// - Cycle limit at least 1 ms forces STOP
// - RUN to STOP sets output lock
// - STOP drives all outputs to zero
// - Analog supply off; preset restart value
// - Remote inputs polled in every state
// - Clear inputs, startup, unlock, clear outputs
// - Read inputs, main block, write outputs
// - Timer and alarm events preempt cycle
// - Timer loads 10 ms to 9990 s
// - Counter loads up to 999, counts
// - Image access by bit, byte, word, dword
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pcs_defines.vh"
module plc_cycle_supervisor #(
    parameter MS_CYCLES = `PCS_MS_NS / `PCS_CLK_NS
) (
    input wire mclk,
    input wire rst,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] localIn,
    input wire [3:0] ioPin,
    input wire [3:0] ioShort,
    input wire overload,
    input wire overheat,
    input wire loadSupply,
    input wire relayVariant,
    input wire [7:0] remIn,
    input wire [1:0] pulseIn,
    input wire startupDone,
    input wire cycleDone,
    input wire eventReq,
    input wire eventDone,
    output reg runStartupBlock,
    output reg runMainCycleBlock,
    output reg runEvent,
    output reg [7:0] localOut,
    output reg [15:0] remOut,
    output reg faultLed,
    output reg loadLed,
    output reg commandOutputLock,
    output reg aoSupply,
    output reg [11:0] aoValue,
    output reg cpuStop,
    output reg irq
);
    localparam S_STOP = 3'd0;
    localparam S_CLRPII = 3'd1;
    localparam S_STARTUP = 3'd2;
    localparam S_CLRPIQ = 3'd3;
    localparam S_READPII = 3'd4;
    localparam S_MAIN = 3'd5;
    localparam S_EVENT = 3'd6;
    localparam S_WRITEPIQ = 3'd7;

    reg [2:0] state;
    reg [23:0] inputProcessImage;
    reg [23:0] outputProcessImage;
    reg [23:0] piqLatch;
    reg [7:0] remLatest;
    reg relayStrap;
    reg ctrlRun;
    reg [1:0] pulseSel;
    reg [15:0] cycLim;
    reg [12:0] aoCfg;
    reg [`PCS_IRQ_W-1:0] irqStat;
    reg [`PCS_IRQ_W-1:0] irqEn;
    reg tmrPend;
    reg [31:0] msCnt;
    reg msTick;
    reg [3:0] tenCnt;
    reg tick10;
    reg [7:0] wdMs;
    reg [15:0] cycMs;
    reg [7:0] blinkMs;
    reg blink;
    reg [31:0] rdMux;
    reg rdErr;

    wire wrEn = psel && penable && pready && pwrite;
    wire rdEn = psel && !penable;
    wire running = (state != S_STOP);
    wire inCycle = state[2];
    wire wdFire = running && msTick && (wdMs == `PCS_WD_MS - 1);
    wire [15:0] limEff = (cycLim < `PCS_MIN_CYC_MS) ? 16'd`PCS_MIN_CYC_MS : cycLim;
    wire ovrFire = inCycle && (cycMs >= limEff);
    wire stopReq = running && (!ctrlRun || wdFire || ovrFire);
    wire anyFault = !relayStrap && (overload || overheat || (|ioShort));
    wire evtPend = eventReq || tmrPend;
    wire [3:0] ioRead;
    wire [9:0] tCur;
    wire [9:0] cCur;
    wire tRun;
    wire tDone;
    wire tmrWr = wrEn && (paddr == `PCS_A_TIMER);
    wire cntWr = wrEn && (paddr == `PCS_A_COUNT);

    // Driven channel reads back its drive unless shorted
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gRead
            assign ioRead[g] = (localOut[g] && !relayStrap) ? !ioShort[g] : ioPin[g];
        end
    endgenerate

    // Byte lane merge for image writes
    function [23:0] laneMerge;
        input [23:0] old;
        input [31:0] wd;
        input [3:0] st;
        begin
            laneMerge[7:0] = st[0] ? wd[7:0] : old[7:0];
            laneMerge[15:8] = st[1] ? wd[15:8] : old[15:8];
            laneMerge[23:16] = st[2] ? wd[23:16] : old[23:16];
        end
    endfunction

    pcs_tc_cell uCell (
        .mclk(mclk),
        .rst(rst),
        .tick10(tick10),
        .tLoad(tmrWr),
        .tStart(pwdata[`PCS_TMR_START]),
        .tVal(pwdata[9:0]),
        .tBase(pwdata[11:10]),
        .cLoad(cntWr && pwdata[`PCS_CNT_LOAD]),
        .cUp(cntWr && pwdata[`PCS_CNT_UP]),
        .cDown(cntWr && pwdata[`PCS_CNT_DOWN]),
        .cVal(pwdata[9:0]),
        .tCur(tCur),
        .tRun(tRun),
        .tDone(tDone),
        .cCur(cCur)
    );

    // Strap is caught by the clock, never by the reset branch
    always @(posedge mclk) begin
        relayStrap <= relayVariant;
    end

    // Millisecond and 10 ms time bases
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            msCnt <= 32'h0;
            msTick <= 1'b0;
            tenCnt <= 4'h0;
            tick10 <= 1'b0;
        end else begin
            msTick <= (msCnt == MS_CYCLES - 1);
            msCnt <= (msCnt == MS_CYCLES - 1) ? 32'h0 : msCnt + 32'h1;
            tick10 <= 1'b0;
            if (msTick) begin
                tenCnt <= (tenCnt == `PCS_TB_MS - 1) ? 4'h0 : tenCnt + 4'h1;
                tick10 <= (tenCnt == `PCS_TB_MS - 1);
            end
        end
    end

    // Watchdog, cycle time and blink counters
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdMs <= 8'h0;
            cycMs <= 16'h0;
            blinkMs <= 8'h0;
            blink <= 1'b0;
        end else begin
            if (!running || state == S_WRITEPIQ) begin
                wdMs <= 8'h0;
            end else if (msTick) begin
                wdMs <= wdMs + 8'h1;
            end
            if (!inCycle || state == S_WRITEPIQ) begin
                cycMs <= 16'h0;
            end else if (msTick && cycMs != 16'hffff) begin
                cycMs <= cycMs + 16'h1;
            end
            if (msTick) begin
                blinkMs <= (blinkMs == `PCS_BLINK_MS - 1) ? 8'h0 : blinkMs + 8'h1;
                if (blinkMs == `PCS_BLINK_MS - 1) begin
                    blink <= !blink;
                end
            end
        end
    end

    // Run sequencer
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= S_STOP;
            runStartupBlock <= 1'b0;
            runMainCycleBlock <= 1'b0;
            runEvent <= 1'b0;
            commandOutputLock <= 1'b1;
            inputProcessImage <= 24'h0;
            piqLatch <= 24'h0;
            remLatest <= 8'h0;
            tmrPend <= 1'b0;
        end else begin
            remLatest <= remIn;
            if (tDone) begin
                tmrPend <= 1'b1;
            end else if (state == S_MAIN && evtPend) begin
                tmrPend <= 1'b0;
            end
            if (stopReq) begin
                state <= S_STOP;
                commandOutputLock <= 1'b1;
                runStartupBlock <= 1'b0;
                runMainCycleBlock <= 1'b0;
                runEvent <= 1'b0;
            end else begin
                case (state)
                    S_STOP: begin
                        if (ctrlRun) begin
                            state <= S_CLRPII;
                        end
                    end
                    S_CLRPII: begin
                        inputProcessImage <= 24'h0;
                        runStartupBlock <= 1'b1;
                        state <= S_STARTUP;
                    end
                    S_STARTUP: begin
                        if (startupDone) begin
                            runStartupBlock <= 1'b0;
                            commandOutputLock <= 1'b0;
                            state <= S_CLRPIQ;
                        end
                    end
                    S_CLRPIQ: begin
                        state <= S_READPII;
                    end
                    S_READPII: begin
                        inputProcessImage <= {remLatest, 4'h0, ioRead, localIn};
                        runMainCycleBlock <= 1'b1;
                        state <= S_MAIN;
                    end
                    S_MAIN: begin
                        if (evtPend) begin
                            runMainCycleBlock <= 1'b0;
                            runEvent <= 1'b1;
                            state <= S_EVENT;
                        end else if (cycleDone) begin
                            runMainCycleBlock <= 1'b0;
                            state <= S_WRITEPIQ;
                        end
                    end
                    S_EVENT: begin
                        if (eventDone) begin
                            runEvent <= 1'b0;
                            runMainCycleBlock <= 1'b1;
                            state <= S_MAIN;
                        end
                    end
                    S_WRITEPIQ: begin
                        piqLatch <= outputProcessImage;
                        state <= S_READPII;
                    end
                    default: begin
                        state <= S_STOP;
                    end
                endcase
            end
        end
    end

    // Physical outputs and indicators
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            localOut <= 8'h00;
            remOut <= 16'h0000;
            faultLed <= 1'b0;
            loadLed <= 1'b0;
            aoSupply <= 1'b0;
            cpuStop <= 1'b1;
            irq <= 1'b0;
        end else begin
            if (!running || commandOutputLock) begin
                localOut <= 8'h00;
                remOut <= 16'h0000;
            end else begin
                localOut[5:0] <= piqLatch[5:0];
                localOut[6] <= pulseSel[0] ? pulseIn[0] : piqLatch[6];
                localOut[7] <= pulseSel[1] ? pulseIn[1] : piqLatch[7];
                remOut <= piqLatch[23:8];
            end
            faultLed <= anyFault && blink;
            loadLed <= loadSupply && !relayStrap;
            aoSupply <= running && !stopReq;
            cpuStop <= !running || stopReq;
            irq <= |(irqStat & irqEn);
        end
    end

    // APB register file; a watchdog or overrun clears the run bit and wins over a write
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            ctrlRun <= 1'b0;
            pulseSel <= 2'h0;
            cycLim <= `PCS_CYCLIM_RST;
            aoCfg <= 13'h0;
            aoValue <= 12'h000;
            irqStat <= {`PCS_IRQ_W{1'b0}};
            irqEn <= {`PCS_IRQ_W{1'b0}};
            outputProcessImage <= 24'h0;
        end else begin
            pready <= rdEn;
            pslverr <= rdEn && rdErr;
            prdata <= (rdEn && !pwrite) ? rdMux : 32'h0;
            if (wrEn && !pslverr) begin
                case (paddr)
                    `PCS_A_CTRL: begin
                        ctrlRun <= pwdata[`PCS_CTRL_RUN];
                        pulseSel <= pwdata[`PCS_CTRL_PULSE_HI:`PCS_CTRL_PULSE_LO];
                    end
                    `PCS_A_CYCLIM: cycLim <= pwdata[15:0];
                    `PCS_A_AOCFG: aoCfg <= pwdata[12:0];
                    `PCS_A_AOVAL: aoValue <= pwdata[11:0];
                    `PCS_A_IRQEN: irqEn <= pwdata[`PCS_IRQ_W-1:0];
                    `PCS_A_IRQCLR: irqStat <= irqStat & ~pwdata[`PCS_IRQ_W-1:0];
                    `PCS_A_OUTIMG: begin
                        outputProcessImage <= laneMerge(outputProcessImage, pwdata, pstrb);
                    end
                    `PCS_A_OUTBIT: begin
                        outputProcessImage[pwdata[4:0]] <= pwdata[`PCS_BIT_VAL];
                    end
                    default: begin
                    end
                endcase
            end
            if (state == S_CLRPIQ) begin
                outputProcessImage <= 24'h0;
                aoValue <= aoCfg[`PCS_AO_HOLD] ? aoValue : aoCfg[11:0];
            end
            if (wdFire || ovrFire) begin
                ctrlRun <= 1'b0;
            end
            if (wdFire) begin
                irqStat[`PCS_IRQ_WD] <= 1'b1;
            end
            if (ovrFire) begin
                irqStat[`PCS_IRQ_OVR] <= 1'b1;
            end
            if (anyFault) begin
                irqStat[`PCS_IRQ_FLT] <= 1'b1;
            end
            if (tDone) begin
                irqStat[`PCS_IRQ_TMR] <= 1'b1;
            end
            if (stopReq) begin
                irqStat[`PCS_IRQ_STOP] <= 1'b1;
            end
        end
    end

    // Read decode; bit index above 23 refused
    always @* begin
        rdMux = 32'h0;
        rdErr = 1'b0;
        case (paddr)
            `PCS_A_CTRL: rdMux = {29'h0, pulseSel, ctrlRun};
            `PCS_A_STATUS: begin
                rdMux = {19'h0, ioRead, relayStrap, aoSupply, commandOutputLock, cpuStop,
                         1'b0, state, anyFault};
            end
            `PCS_A_OUTIMG: rdMux = {8'h0, outputProcessImage};
            `PCS_A_INIMG: rdMux = {8'h0, inputProcessImage};
            `PCS_A_CYCLIM: rdMux = {16'h0, cycLim};
            `PCS_A_TIMER: rdMux = {16'h0, tRun, 5'h0, tCur};
            `PCS_A_COUNT: rdMux = {22'h0, cCur};
            `PCS_A_OUTBIT: rdErr = pwrite && (pwdata[4:0] > 5'd23);
            `PCS_A_IRQSTAT: rdMux = {{(32-`PCS_IRQ_W){1'b0}}, irqStat};
            `PCS_A_IRQCLR: rdMux = 32'h0;
            `PCS_A_IRQEN: rdMux = {{(32-`PCS_IRQ_W){1'b0}}, irqEn};
            `PCS_A_AOCFG: rdMux = {19'h0, aoCfg};
            `PCS_A_AOVAL: rdMux = {20'h0, aoValue};
            `PCS_A_REMIN: rdMux = {24'h0, remLatest};
            default: rdErr = 1'b1;
        endcase
    end
endmodule

// ---- pcs_defines.vh ----
// Constants for the cycle supervisor
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH
`define PCS_CLK_NS 100
`define PCS_MS_NS 1000000
`define PCS_WD_MS 100
`define PCS_MIN_CYC_MS 1
`define PCS_BLINK_MS 250
`define PCS_TB_MS 10
`define PCS_CNT_MAX 999
`define PCS_A_CTRL 8'h00
`define PCS_A_STATUS 8'h04
`define PCS_A_OUTIMG 8'h08
`define PCS_A_INIMG 8'h0c
`define PCS_A_CYCLIM 8'h10
`define PCS_A_TIMER 8'h14
`define PCS_A_COUNT 8'h18
`define PCS_A_OUTBIT 8'h1c
`define PCS_A_IRQSTAT 8'h20
`define PCS_A_IRQCLR 8'h24
`define PCS_A_IRQEN 8'h28
`define PCS_A_AOCFG 8'h2c
`define PCS_A_AOVAL 8'h30
`define PCS_A_REMIN 8'h34
`define PCS_CTRL_RUN 0
`define PCS_CTRL_PULSE_LO 1
`define PCS_CTRL_PULSE_HI 2
`define PCS_TMR_START 12
`define PCS_CNT_LOAD 12
`define PCS_CNT_UP 13
`define PCS_CNT_DOWN 14
`define PCS_BIT_VAL 5
`define PCS_AO_HOLD 12
`define PCS_IRQ_WD 0
`define PCS_IRQ_OVR 1
`define PCS_IRQ_FLT 2
`define PCS_IRQ_TMR 3
`define PCS_IRQ_STOP 4
`define PCS_IRQ_W 5
`define PCS_CYCLIM_RST 16'h0096
`endif

// ---- pcs_tc_cell.v ----
// Timer and counter cell pair
`timescale 1ns/1ps
`include "pcs_defines.vh"
module pcs_tc_cell (
    input wire mclk,
    input wire rst,
    input wire tick10,
    input wire tLoad,
    input wire tStart,
    input wire [9:0] tVal,
    input wire [1:0] tBase,
    input wire cLoad,
    input wire cUp,
    input wire cDown,
    input wire [9:0] cVal,
    output reg [9:0] tCur,
    output reg tRun,
    output reg tDone,
    output reg [9:0] cCur
);
    reg [9:0] pre;
    reg [1:0] base;

    // Values above the ceiling saturate instead of wrapping
    function [9:0] clampMax;
        input [9:0] v;
        begin
            clampMax = (v > 10'd`PCS_CNT_MAX) ? 10'd`PCS_CNT_MAX : v;
        end
    endfunction

    function [9:0] baseDiv;
        input [1:0] b;
        begin
            case (b)
                2'd0: baseDiv = 10'd0;
                2'd1: baseDiv = 10'd9;
                2'd2: baseDiv = 10'd99;
                default: baseDiv = 10'd999;
            endcase
        end
    endfunction

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tCur <= 10'h000;
            tRun <= 1'b0;
            tDone <= 1'b0;
            pre <= 10'h000;
            base <= 2'h0;
        end else begin
            tDone <= 1'b0;
            if (tLoad) begin
                tCur <= (tVal == 10'h000) ? 10'h001 : clampMax(tVal);
                base <= tBase;
                pre <= 10'h000;
                tRun <= tStart;
            end else if (tRun && tick10) begin
                if (pre == baseDiv(base)) begin
                    pre <= 10'h000;
                    tCur <= tCur - 10'h001;
                    if (tCur == 10'h001) begin
                        tRun <= 1'b0;
                        tDone <= 1'b1;
                    end
                end else begin
                    pre <= pre + 10'h001;
                end
            end
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cCur <= 10'h000;
        end else if (cLoad) begin
            cCur <= clampMax(cVal);
        end else if (cUp && !cDown && cCur != 10'd`PCS_CNT_MAX) begin
            cCur <= cCur + 10'h001;
        end else if (cDown && !cUp && cCur != 10'h000) begin
            cCur <= cCur - 10'h001;
        end
    end
endmodule

// ---- pcs_sup_assertions.sv ----
// Port-level property checker for the cycle supervisor
`timescale 1ns/1ps
module pcs_sup_assertions #(
    parameter MS_CYCLES = 10
) (
    input wire mclk,
    input wire rst,
    input wire startupDone,
    input wire cycleDone,
    input wire eventReq,
    input wire eventDone,
    input wire overload,
    input wire overheat,
    input wire relayVariant,
    input wire runStartupBlock,
    input wire runMainCycleBlock,
    input wire runEvent,
    input wire [7:0] localOut,
    input wire [15:0] remOut,
    input wire faultLed,
    input wire loadLed,
    input wire commandOutputLock,
    input wire aoSupply,
    input wire cpuStop
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Slack for state hops before the stop
    localparam int WD_MAX = 100 * MS_CYCLES + 4;
    localparam int BL_MAX = 250 * MS_CYCLES + 4;
    int wdCnt;
    int ledCnt;
    logic ledQ;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdCnt <= 0;
            ledCnt <= 0;
            ledQ <= 1'b0;
        end else begin
            ledQ <= faultLed;
            wdCnt <= (cpuStop || (runMainCycleBlock && cycleDone)) ? 0 : wdCnt + 1;
            ledCnt <= (!(overload || overheat) || relayVariant || faultLed != ledQ) ? 0 : ledCnt + 1;
        end
    end
    sequence s_boot_ack;
        runStartupBlock && startupDone;
    endsequence
    sequence s_unlock_run;
        !commandOutputLock ##[1:4] runMainCycleBlock;
    endsequence
    a_stop_sets_lock: assert property ($rose(cpuStop) |-> ##[0:1] commandOutputLock)
        else $error("lock missing after stop");
    a_stop_outs_zero: assert property (cpuStop && $past(cpuStop) |-> localOut == 8'h00 && remOut == 16'h0000)
        else $error("outputs driven in stop");
    a_stop_ao_off: assert property (cpuStop && $past(cpuStop) |-> !aoSupply)
        else $error("analog supply on in stop");
    a_boot_locked: assert property (runStartupBlock |-> commandOutputLock)
        else $error("lock released during startup");
    a_boot_order: assert property (s_boot_ack |=> s_unlock_run)
        else $error("startup sequence broken");
    a_event_preempt: assert property (runMainCycleBlock && eventReq && !cycleDone |=> runEvent && !runMainCycleBlock || cpuStop)
        else $error("event did not preempt cycle");
    a_event_resume: assert property (runEvent && eventDone |=> runMainCycleBlock || cpuStop)
        else $error("cycle did not resume");
    a_wd_bound: assert property (wdCnt <= WD_MAX)
        else $error("watchdog late");
    a_fault_blink: assert property (ledCnt <= BL_MAX)
        else $error("fault indicator steady");
    a_relay_dark: assert property ($past(relayVariant) && $past(relayVariant, 2) |-> !faultLed && !loadLed)
        else $error("relay variant shows indicator");
endmodule
bind plc_cycle_supervisor pcs_sup_assertions #(.MS_CYCLES(MS_CYCLES)) chk_u (.mclk, .rst,
    .startupDone, .cycleDone, .eventReq, .eventDone, .overload, .overheat, .relayVariant,
    .runStartupBlock, .runMainCycleBlock, .runEvent, .localOut, .remOut, .faultLed,
    .loadLed, .commandOutputLock, .aoSupply, .cpuStop);

// ---- pcs_io_model.sv ----
// Process I/O and remote slave model
`timescale 1ns/1ps
module pcs_io_model (
    input wire [7:0] localOut,
    input wire [3:0] shortSet,
    input wire [7:0] inSet,
    input wire [7:0] remSet,
    output wire [3:0] ioPin,
    output wire [3:0] ioShort,
    output wire [7:0] localIn,
    output wire [7:0] remIn
);
    // A short clamps the shared pin low
    assign ioPin = (localOut[3:0] | inSet[3:0]) & ~shortSet;
    assign ioShort = shortSet;
    assign localIn = inSet;
    assign remIn = remSet;
endmodule

// ---- testbench.sv ----
// Self-checking bench for the cycle supervisor
`timescale 1ns/1ps
`include "pcs_defines.vh"
module testbench;
    reg mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    reg [7:0] paddr = 0, inSet = 0, remSet = 0;
    reg [31:0] pwdata = 0, rd;
    reg [3:0] pstrb = 4'hf, shortSet = 0;
    reg startupDone = 0, cycleDone = 0, eventReq = 0, eventDone = 0, err;
    reg overload = 0, overheat = 0, loadSupply = 1, relayVariant = 0;
    wire [31:0] prdata;
    wire pready, pslverr, runStartupBlock, runMainCycleBlock, runEvent, faultLed, loadLed;
    wire commandOutputLock, aoSupply, cpuStop, irq;
    wire [7:0] localIn, remIn, localOut;
    wire [3:0] ioPin, ioShort;
    wire [15:0] remOut;
    wire [11:0] aoValue;
    integer miscompares = 0, total_checks = 0, n, h;
    always #50 mclk = ~mclk;
    plc_cycle_supervisor #(.MS_CYCLES(10)) dut_u (.mclk, .rst, .paddr, .psel, .penable,
        .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .localIn, .ioPin, .ioShort,
        .overload, .overheat, .loadSupply, .relayVariant, .remIn, .pulseIn(2'b00),
        .startupDone, .cycleDone, .eventReq, .eventDone, .runStartupBlock,
        .runMainCycleBlock, .runEvent, .localOut, .remOut, .faultLed, .loadLed,
        .commandOutputLock, .aoSupply, .aoValue, .cpuStop, .irq);
    pcs_io_model io_u (.localOut, .shortSet, .inSet, .remSet, .ioPin, .ioShort, .localIn,
        .remIn);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1;
            n = 0;
            @(posedge mclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge mclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    function sig(input [1:0] k);
        sig = k == 0 ? runStartupBlock : k == 1 ? runMainCycleBlock : k == 2 ? runEvent : cpuStop;
    endfunction
    // n keeps cycles waited
    task wt(input [1:0] k);
        begin
            n = 0;
            while (sig(k) !== 1'b1 && n < 3000) begin
                n = n + 1;
                @(posedge mclk);
            end
        end
    endtask
    task end_cycle;
        begin
            cycleDone <= 1;
            @(posedge mclk);
            cycleDone <= 0;
            repeat (2) @(posedge mclk);
            wt(1);
        end
    endtask
    task t_reset;
        begin
            chk({commandOutputLock, cpuStop, localOut}, 10'h300);
            apb(`PCS_A_STATUS, 0, 0);
            chk(rd[6:5], 2'b11);
            apb(8'h38, 0, 0);
            chk({err, rd[30:0]}, 32'h80000000);
        end
    endtask
    task t_boot;
        begin
            apb(`PCS_A_OUTIMG, 1, 32'h00ffffff);
            apb(`PCS_A_AOCFG, 1, 32'h000005a5);
            apb(`PCS_A_CTRL, 1, 32'h1);
            wt(0);
            chk(commandOutputLock, 1);
            startupDone <= 1;
            @(posedge mclk);
            startupDone <= 0;
            wt(1);
            chk({commandOutputLock, aoValue}, 13'h05a5);
            apb(`PCS_A_OUTIMG, 0, 0);
            chk(rd, 0);
        end
    endtask
    task t_cycle;
        begin
            shortSet <= 4'h4;
            inSet <= 8'h30;
            remSet <= 8'h96;
            apb(`PCS_A_OUTIMG, 1, 32'hff3c5a0f);
            end_cycle;
            repeat (2) @(posedge mclk);
            chk({remOut, localOut}, 24'h3c5a0f);
            apb(`PCS_A_STATUS, 0, 0);
            chk(rd[12:9], 4'hb);
            apb(`PCS_A_INIMG, 0, 0);
            chk({rd[31:16], rd[7:0]}, 24'h009630);
        end
    endtask
    task t_event;
        begin
            eventReq <= 1;
            wt(2);
            chk(runMainCycleBlock, 0);
            eventReq <= 0;
            repeat (3) @(posedge mclk);
            chk(runEvent, 1);
            eventDone <= 1;
            @(posedge mclk);
            eventDone <= 0;
            wt(1);
            chk(runEvent, 0);
        end
    endtask
    task t_overrun;
        begin
            shortSet <= 4'h0;
            apb(`PCS_A_IRQEN, 1, 32'h2);
            end_cycle;
            apb(`PCS_A_CYCLIM, 1, 32'h2);
            end_cycle;
            wt(3);
            chk(n >= 11 && n <= 20, 1);
            repeat (2) @(posedge mclk);
            chk({commandOutputLock, aoSupply, remOut, localOut}, 26'h2000000);
            apb(`PCS_A_IRQSTAT, 0, 0);
            chk({rd[4], rd[1], irq}, 3'b111);
            apb(`PCS_A_IRQEN, 1, 32'h0);
            repeat (2) @(posedge mclk);
            chk(irq, 0);
            apb(`PCS_A_IRQCLR, 1, 32'h1f);
            apb(`PCS_A_IRQSTAT, 0, 0);
            chk(rd[4:0], 0);
            remSet <= 8'h5c;
            apb(`PCS_A_REMIN, 0, 0);
            chk(rd[7:0], 8'h5c);
            apb(`PCS_A_CYCLIM, 1, 32'd200);
        end
    endtask
    task t_watch;
        begin
            repeat (4) begin
                repeat (300) @(posedge mclk);
                end_cycle;
            end
            chk(cpuStop, 0);
            wt(3);
            chk(n >= 990 && n <= 1003, 1);
            apb(`PCS_A_IRQSTAT, 0, 0);
            chk(rd[0], 1);
        end
    endtask
    task t_cells;
        begin
            apb(`PCS_A_COUNT, 1, 32'h13e7);
            apb(`PCS_A_COUNT, 0, 0);
            chk(rd[9:0], 10'd999);
            apb(`PCS_A_COUNT, 1, 32'h1005);
            apb(`PCS_A_COUNT, 1, 32'h2000);
            apb(`PCS_A_COUNT, 1, 32'h2000);
            apb(`PCS_A_COUNT, 1, 32'h4000);
            apb(`PCS_A_COUNT, 1, 32'h6000);
            apb(`PCS_A_COUNT, 0, 0);
            chk(rd[9:0], 10'd6);
            apb(`PCS_A_OUTBIT, 1, 32'h31);
            apb(`PCS_A_OUTIMG, 0, 0);
            chk(rd, 32'h20000);
            apb(`PCS_A_TIMER, 1, 32'h1003);
            apb(`PCS_A_TIMER, 0, 0);
            chk(rd[15], 1);
            repeat (450) @(posedge mclk);
            apb(`PCS_A_TIMER, 0, 0);
            chk({rd[15], rd[9:0]}, 0);
            apb(`PCS_A_IRQSTAT, 0, 0);
            chk(rd[3], 1);
        end
    endtask
    task t_fault;
        begin
            overload <= 1;
            h = 0;
            repeat (6000) begin
                @(posedge mclk);
                h = h + (faultLed === 1'b1);
            end
            chk({h >= 2400 && h <= 3600, loadLed}, 2'b11);
            apb(`PCS_A_IRQSTAT, 0, 0);
            chk(rd[2], 1);
            relayVariant <= 1;
            repeat (3) @(posedge mclk);
            chk({faultLed, loadLed}, 0);
            overload <= 0;
            relayVariant <= 0;
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d miscompares %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #3000000;
        miscompares = miscompares + 1;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        t_reset;
        t_boot;
        t_cycle;
        t_event;
        t_overrun;
        t_boot;
        t_watch;
        t_cells;
        t_fault;
        print_verdict;
    end
endmodule
